// ---- hdl/rfdrl_regs.vh ----
// Functional notes
// - low variants: swallow count bits 6..3, 0-15
// - high variant: swallow count bits 7..3, 0-31
// - low variants: binary count bits 21..7, min 3
// - high variant: binary count bits 21..8, min 3
// - low variants: select bit 22 picks 8/9 or 16/17
// - high variant: select bit 22 picks 16/17 or 32/33
// - bit 23 powers down the loop
// - power-down plus pump hiz picks sync/async
// - timeout is 12 bits at 14..3
// - timeout 0: pin hiz, gain bit rules
// - timeout 1: pin low, pump forced high
// - timeout 2: pin driven low, gain bit rules
// - timeout 3: pin driven high, gain bit rules
// - timeout 4+: low and high pump for count
// - new timeout latched on next comparison event
// - third register holds IF fields and mux bits
// - gain bit picks 1 mA or 4 mA
// - pump hiz acts immediately on change
`ifndef RFDRL_REGS_VH
`define RFDRL_REGS_VH
`define RFDRL_SEL_FEEDBACK 3'h1
`define RFDRL_SEL_TIMEOUT  3'h2
`define RFDRL_SEL_IFREF    3'h3
`define RFDRL_SEL_PUMP     3'h0
`define RFDRL_PD_BIT       23
`define RFDRL_PSEL_BIT     22
`define RFDRL_TOC_MSB      14
`define RFDRL_TOC_LSB      3
`define RFDRL_PUMP_GAIN_BIT 19
`define RFDRL_PUMP_HIZ_BIT  20
`define RFDRL_IF_POL_BIT   18
`define RFDRL_IF_GAIN_BIT  19
`define RFDRL_IF_HIZ_BIT   20
`define RFDRL_IF_RST_BIT   21
`define RFDRL_WORD_RESET   24'h000000
`define RFDRL_TOC_RESET    12'h000
`define RFDRL_TOC_OFF      12'h000
`define RFDRL_TOC_MANUAL   12'h001
`define RFDRL_TOC_GP_LOW   12'h002
`define RFDRL_TOC_GP_HIGH  12'h003
`endif

// ---- hdl/rfdrl_timeout.v ----
`timescale 1ns/1ps
`include "rfdrl_regs.vh"
module rfdrl_timeout (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        pfd_event,
    input  wire [11:0] pending_toc,
    output reg  [11:0] active_toc,
    output reg  [11:0] event_count,
    output reg         auto_done
);
    //==========================================================
    // latch setting and count events
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_toc  <= `RFDRL_TOC_RESET;
            event_count <= 12'h000;
            auto_done   <= 1'b0;
        end else if (clk_en && pfd_event) begin
            active_toc  <= pending_toc;
            if (pending_toc != active_toc) begin
                event_count <= 12'h001;
                auto_done   <= 1'b0;
            end else if (!auto_done) begin
                if (event_count >= active_toc) begin
                    auto_done <= 1'b1;
                end else begin
                    event_count <= event_count + 12'h001;
                end
            end
        end
    end
endmodule // rfdrl_timeout

// ---- hdl/rfdrl_core.v ----
`timescale 1ns/1ps
`include "rfdrl_regs.vh"
module rfdrl_core #(
    parameter HIGH_VARIANT = 0
) (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        word_load,
    input  wire [23:0] word_data,
    input  wire        pfd_event,
    output reg  [4:0]  rf_swallow_count,
    output reg  [14:0] rf_binary_count,
    output reg  [5:0]  rf_prescaler_low,
    output reg         rf_power_down,
    output reg         rf_power_down_async,
    output reg         rf_pump_hiz,
    output reg         rf_pump_high,
    output reg         rf_rapid_lock_pin_o,
    output reg         rf_rapid_lock_pin_oe,
    output reg  [14:0] if_ref_divide,
    output reg         if_pfd_polarity,
    output reg         if_pump_gain,
    output reg         if_pump_hiz,
    output reg         if_counter_reset,
    output reg  [1:0]  output_select
);
    //==========================================================
    // stored words
    reg         rf_pump_gain;
    reg  [11:0] pending_toc;
    wire [11:0] active_toc;
    wire [11:0] event_count;
    wire        auto_done;
    reg         next_pin_o;
    reg         next_pin_oe;
    reg         next_high;
    wire [2:0]  sel = word_data[2:0];

    rfdrl_timeout u_timeout (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .clk_en      (clk_en),
        .pfd_event   (pfd_event),
        .pending_toc (pending_toc),
        .active_toc  (active_toc),
        .event_count (event_count),
        .auto_done   (auto_done)
    );

    //==========================================================
    // word decode
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rf_swallow_count <= 5'h00;
            rf_binary_count  <= 15'h0000;
            // lower modulus of the select-0 pair for the fitted variant
            rf_prescaler_low <= (HIGH_VARIANT != 0) ? 6'h10 : 6'h08;
            rf_power_down    <= 1'b0;
            rf_pump_gain     <= 1'b0;
            rf_pump_hiz      <= 1'b0;
            pending_toc      <= `RFDRL_TOC_RESET;
            if_ref_divide    <= 15'h0000;
            if_pfd_polarity  <= 1'b0;
            if_pump_gain     <= 1'b0;
            if_pump_hiz      <= 1'b0;
            if_counter_reset <= 1'b0;
            output_select    <= 2'h0;
        end else if (clk_en && word_load) begin
            case (sel)
                `RFDRL_SEL_FEEDBACK: begin
                    if (HIGH_VARIANT != 0) begin
                        rf_swallow_count <= word_data[7:3];
                        rf_binary_count  <= {1'b0, word_data[21:8]};
                        rf_prescaler_low <= word_data[`RFDRL_PSEL_BIT] ? 6'h20 : 6'h10;
                    end else begin
                        rf_swallow_count <= {1'b0, word_data[6:3]};
                        rf_binary_count  <= word_data[21:7];
                        rf_prescaler_low <= word_data[`RFDRL_PSEL_BIT] ? 6'h10 : 6'h08;
                    end
                    rf_power_down <= word_data[`RFDRL_PD_BIT];
                end
                `RFDRL_SEL_TIMEOUT: begin
                    pending_toc <= word_data[`RFDRL_TOC_MSB:`RFDRL_TOC_LSB];
                end
                `RFDRL_SEL_IFREF: begin
                    if_ref_divide    <= word_data[17:3];
                    if_pfd_polarity  <= word_data[`RFDRL_IF_POL_BIT];
                    if_pump_gain     <= word_data[`RFDRL_IF_GAIN_BIT];
                    if_pump_hiz      <= word_data[`RFDRL_IF_HIZ_BIT];
                    if_counter_reset <= word_data[`RFDRL_IF_RST_BIT];
                    output_select    <= word_data[23:22];
                end
                `RFDRL_SEL_PUMP: begin
                    rf_pump_gain <= word_data[`RFDRL_PUMP_GAIN_BIT];
                    rf_pump_hiz  <= word_data[`RFDRL_PUMP_HIZ_BIT];
                end
                default: begin
                    rf_pump_hiz <= rf_pump_hiz;
                end
            endcase
        end
    end

    //==========================================================
    // rapid-lock pin and pump gain
    always @* begin
        next_high   = rf_pump_gain;
        next_pin_o  = 1'b0;
        next_pin_oe = 1'b0;
        case (active_toc)
            `RFDRL_TOC_OFF: begin
                next_pin_oe = 1'b0;
            end
            `RFDRL_TOC_MANUAL: begin
                next_pin_oe = 1'b1;
                next_high   = 1'b1;
            end
            `RFDRL_TOC_GP_LOW: begin
                next_pin_oe = 1'b1;
            end
            `RFDRL_TOC_GP_HIGH: begin
                next_pin_oe = 1'b1;
                next_pin_o  = 1'b1;
            end
            default: begin
                next_pin_oe = !auto_done;
                next_high   = !auto_done;
            end
        endcase
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rf_pump_high         <= 1'b0;
            rf_rapid_lock_pin_o  <= 1'b0;
            rf_rapid_lock_pin_oe <= 1'b0;
            rf_power_down_async          <= 1'b0;
        end else if (clk_en) begin
            rf_pump_high         <= next_high;
            rf_rapid_lock_pin_o  <= next_pin_o;
            rf_rapid_lock_pin_oe <= next_pin_oe;
            rf_power_down_async          <= rf_power_down & rf_pump_hiz;
        end
    end
endmodule // rfdrl_core

// ---- sim/rfdrl_core_props.sv ----
`timescale 1ns/1ps
module rfdrl_core_props #(
    parameter HIGH_VARIANT = 0
) (
    input wire        mclk,
    input wire        arst_n,
    input wire        clk_en,
    input wire        word_load,
    input wire [23:0] word_data,
    input wire        pfd_event,
    input wire [4:0]  rf_swallow_count,
    input wire [14:0] rf_binary_count,
    input wire [5:0]  rf_prescaler_low,
    input wire        rf_power_down,
    input wire        rf_power_down_async,
    input wire        rf_pump_hiz,
    input wire        rf_rapid_lock_pin_oe,
    input wire [14:0] if_ref_divide,
    input wire [1:0]  output_select
);
default clocking cb @(posedge mclk); endclocking
default disable iff (!arst_n);
wire ld = clk_en && word_load;
// ====================
// word loads, async power down and pin timing
a_swallow_load: assert property (ld && word_data[2:0] == 3'h1 |=>
    rf_swallow_count == (HIGH_VARIANT ? $past(word_data[7:3]) : {1'b0, $past(word_data[6:3])}))
    else $error("swallow count wrong");
a_binary_load: assert property (ld && word_data[2:0] == 3'h1 |=>
    rf_binary_count == (HIGH_VARIANT ? {1'b0, $past(word_data[21:8])} : $past(word_data[21:7])))
    else $error("binary count wrong");
a_prescale_load: assert property (ld && word_data[2:0] == 3'h1 |=>
    rf_prescaler_low == (6'h8 << ($past(word_data[22]) + HIGH_VARIANT))) else $error("prescaler wrong");
a_powerdown_load: assert property (ld && word_data[2:0] == 3'h1 |=>
    rf_power_down == $past(word_data[23])) else $error("power down wrong");
a_pump_hiz_load: assert property (ld && word_data[2:0] == 3'h0 |=>
    rf_pump_hiz == $past(word_data[20])) else $error("pump hiz wrong");
a_if_word_load: assert property (ld && word_data[2:0] == 3'h3 |=>
    if_ref_divide == $past(word_data[17:3]) && output_select == $past(word_data[23:22]))
    else $error("if word wrong");
a_foreign_sel: assert property (ld && word_data[2] |=>
    $stable(rf_binary_count) && $stable(if_ref_divide)) else $error("unknown select used");
a_async_pd: assert property (rf_power_down && rf_pump_hiz |-> ##[0:1] rf_power_down_async)
    else $error("async power down missing");
a_pin_on_event: assert property ($changed(rf_rapid_lock_pin_oe) |->
    $past(pfd_event) || $past(pfd_event, 2)) else $error("pin moved without event");
endmodule // rfdrl_core_props

// ---- sim/rfdrl_host.sv ----
`timescale 1ns/1ps
module rfdrl_host (
    input wire        mclk,
    output reg        word_load,
    output reg [23:0] word_data
);
initial begin
    word_load = 1'b0;
    word_data = 24'h0;
end
// ====================
// word writes
// select in low bits
task send(input [23:0] w);
    begin
        @(posedge mclk);
        word_load <= 1'b1;
        word_data <= w;
        @(posedge mclk);
        word_load <= 1'b0;
        word_data <= ~w;
    end
endtask
endmodule // rfdrl_host

// ---- sim/rfdrl_core_test.sv ----
`timescale 1ns/1ps
module rfdrl_core_test;
reg mclk = 1'b0;
reg arst_n = 1'b0;
reg pfd_event = 1'b0;
reg clk_en = 1'b1;
wire word_load, rf_power_down, rf_power_down_async, rf_pump_hiz, rf_pump_high, pin_o, pin_oe;
wire if_pol, if_gain, if_hiz, if_rst;
wire [23:0] word_data;
wire [4:0] rf_swallow_count;
wire [14:0] rf_binary_count, if_ref_divide;
wire [5:0] rf_prescaler_low;
wire [1:0] output_select;
integer num_errors = 0, total_checks = 0, cycles = 0, m;
reg [2:0] prev;
reg [2:0] tab [0:4];
always #2.5 mclk = ~mclk;
rfdrl_host i_rfdrl_host (.mclk(mclk), .word_load(word_load), .word_data(word_data));
rfdrl_core i_rfdrl_core (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .word_load(word_load),
    .word_data(word_data), .pfd_event(pfd_event), .rf_swallow_count(rf_swallow_count),
    .rf_binary_count(rf_binary_count), .rf_prescaler_low(rf_prescaler_low),
    .rf_power_down(rf_power_down), .rf_power_down_async(rf_power_down_async), .rf_pump_hiz(rf_pump_hiz),
    .rf_pump_high(rf_pump_high), .rf_rapid_lock_pin_o(pin_o), .rf_rapid_lock_pin_oe(pin_oe),
    .if_ref_divide(if_ref_divide), .if_pfd_polarity(if_pol), .if_pump_gain(if_gain),
    .if_pump_hiz(if_hiz), .if_counter_reset(if_rst), .output_select(output_select));
// ====================
// helpers
task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    end
endtask
task pulse;
    begin
        @(posedge mclk) pfd_event <= 1'b1;
        @(posedge mclk) pfd_event <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    end
endtask
task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end
endtask
always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
        num_errors = num_errors + 1;
        wrap_up;
    end
end
// ====================
// tests
initial begin
    tab[0] = 3'b000;
    tab[1] = 3'b101;
    tab[2] = 3'b100;
    tab[3] = 3'b110;
    tab[4] = 3'b101;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk("prescaler reset", 16'h8, rf_prescaler_low);
    i_rfdrl_host.send({1'b1, 1'b1, 15'h7fff, 4'hf, 3'h1});
    #1;
    chk("swallow max", 16'hf, rf_swallow_count);
    chk("binary max", 16'h7fff, rf_binary_count);
    chk("prescaler high", 16'h10, rf_prescaler_low);
    chk("power down", 16'h1, rf_power_down);
    i_rfdrl_host.send({1'b0, 1'b0, 15'h3, 4'h0, 3'h1});
    #1;
    chk("binary min", 16'h3, rf_binary_count);
    chk("prescaler low", 16'h8, rf_prescaler_low);
    i_rfdrl_host.send(24'h7ffffd);
    #1;
    chk("ignored select", 16'h3, rf_binary_count);
    $display("test feedback done");
    i_rfdrl_host.send({3'h0, 1'b1, 1'b1, 16'h0, 3'h0});
    #1;
    chk("pump hiz", 16'h1, rf_pump_hiz);
    i_rfdrl_host.send({1'b1, 1'b0, 15'h3, 4'h0, 3'h1});
    @(posedge mclk);
    #1;
    chk("async power down", 16'h1, rf_power_down_async);
    chk("pump gain high", 16'h1, rf_pump_high);
    i_rfdrl_host.send({2'b10, 1'b1, 1'b1, 1'b0, 1'b1, 15'h1234, 3'h3});
    #1;
    chk("if divide", 16'h1234, if_ref_divide);
    chk("if flags", 16'h2d, {output_select, if_rst, if_hiz, if_gain, if_pol});
    @(posedge mclk);
    clk_en <= 1'b0;
    i_rfdrl_host.send({1'b0, 1'b0, 15'h55, 4'h0, 3'h1});
    #1;
    chk("frozen binary", 16'h3, rf_binary_count);
    @(posedge mclk);
    clk_en <= 1'b1;
    i_rfdrl_host.send(24'h0);
    $display("test pump and if done");
    prev = 3'b000;
    for (m = 0; m < 5; m = m + 1) begin
        i_rfdrl_host.send({9'h0, m[11:0], 3'h2});
        #1;
        chk("before event", prev, {pin_oe, pin_o, rf_pump_high});
        pulse;
        chk("timeout mode", tab[m], {pin_oe, pin_o, rf_pump_high});
        prev = tab[m];
    end
    repeat (3) pulse;
    chk("auto running", 16'h5, {pin_oe, pin_o, rf_pump_high});
    @(posedge mclk);
    clk_en <= 1'b0;
    pulse;
    chk("frozen event", 16'h5, {pin_oe, pin_o, rf_pump_high});
    @(posedge mclk);
    clk_en <= 1'b1;
    pulse;
    chk("auto expired", 16'h0, {pin_oe, pin_o, rf_pump_high});
    $display("test timeout done");
    wrap_up;
end
endmodule // rfdrl_core_test
bind rfdrl_core rfdrl_core_props #(.HIGH_VARIANT(HIGH_VARIANT)) i_rfdrl_core_props (.mclk, .arst_n,
    .clk_en, .word_load, .word_data, .pfd_event, .rf_swallow_count, .rf_binary_count,
    .rf_prescaler_low, .rf_power_down, .rf_power_down_async, .rf_pump_hiz, .rf_rapid_lock_pin_oe,
    .if_ref_divide, .output_select);
